//--- rtl/port_pkg.sv
// package with register map, mode encodings and carrier types of the port block
package port_pkg;

	// register addresses on the internal register bus
	localparam logic [7:0] ADDR_WIDE_DATA     = 8'h80;
	localparam logic [7:0] ADDR_WIDE_TYPE_A   = 8'h84;
	localparam logic [7:0] ADDR_WIDE_TYPE_B   = 8'h85;
	localparam logic [7:0] ADDR_THIRD_DATA    = 8'h90;
	localparam logic [7:0] ADDR_THIRD_TYPE_A  = 8'h91;
	localparam logic [7:0] ADDR_THIRD_TYPE_B  = 8'h92;
	localparam logic [7:0] ADDR_NARROW_DATA   = 8'hB0;
	localparam logic [7:0] ADDR_NARROW_TYPE_A = 8'hB1;
	localparam logic [7:0] ADDR_NARROW_TYPE_B = 8'hB2;
	localparam logic [7:0] ADDR_CLK_CTRL      = 8'hC8;
	localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hC9;
	localparam logic [7:0] ADDR_IRQ_MASK      = 8'hCA;

	// reset values
	localparam logic [7:0] RST_TYPE_A         = 8'hFF;
	localparam logic [7:0] RST_TYPE_B         = 8'h00;
	localparam logic [7:0] RST_THIRD_TYPE_A   = 8'hD3;
	localparam logic [7:0] RST_NARROW_TYPE_A  = 8'h03;
	localparam logic [7:0] RST_DATA           = 8'hFF;
	localparam logic [7:0] RST_ZERO           = 8'h00;

	// implemented-bit masks
	localparam logic [7:0] THIRD_MODE_MASK    = 8'hDF;
	localparam logic [7:0] THIRD_INPUT_ONLY   = 8'h20;
	localparam logic [7:0] NARROW_MASK        = 8'h03;

	// field positions
	localparam int CLK_OUT_EN_BIT   = 6;
	localparam int NARROW_CLK_BIT   = 0;
	localparam int NARROW_OSC_BIT   = 1;
	localparam int TIMER_PIN_BIT    = 7;
	localparam int CMP_TWO_PIN_BIT  = 0;
	localparam int CMP_ONE_PIN_BIT  = 6;

	// cpu clock source selected by non-volatile configuration
	localparam logic [1:0] SRC_RC       = 2'h0;
	localparam logic [1:0] SRC_WATCHDOG = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	localparam logic [1:0] SRC_CRYSTAL  = 2'h3;

	// output type per pin from {type_a, type_b}
	typedef enum logic [3:0] {
		MODE_QUASI      = 4'b0001,
		MODE_PUSH_PULL  = 4'b0010,
		MODE_INPUT_ONLY = 4'b0100,
		MODE_OPEN_DRAIN = 4'b1000
	} pin_mode_t;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// pin drive bundle of one eight-bit port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pull_en;
	} pin_drive_t;

endpackage

//--- rtl/micro_port.sv
// port pin logic with mode registers, alternate functions and keypad interrupt
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

module micro_port
	import port_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire reg_req_t   i_req,
	output logic [7:0]      o_rdata,
	input  wire logic [7:0] i_wide_pin,
	output pin_drive_t      o_wide_drive,
	input  wire logic [7:0] i_third_pin,
	output pin_drive_t      o_third_drive,
	input  wire logic [1:0] i_narrow_pin,
	output logic [1:0]      o_narrow_out,
	output logic [1:0]      o_narrow_oe_n,
	output logic [1:0]      o_narrow_pull_en,
	input  wire logic [1:0] i_clk_source,
	input  wire logic       i_timer_uses_crystal,
	input  wire logic       i_comparator_one_output,
	input  wire logic       i_comparator_two_output,
	input  wire logic       i_cmp_one_out_en,
	input  wire logic       i_cmp_two_out_en,
	input  wire logic       i_timer_one_out,
	input  wire logic       i_timer_one_out_en,
	output logic            o_timer_one_pin,
	output logic [7:0]      o_keypad_input,
	output logic            o_irq
);

	logic [7:0] wide_data_q, wide_ta_q, wide_tb_q;
	logic [7:0] third_data_q, third_ta_q, third_tb_q;
	logic [1:0] narrow_data_q, narrow_ta_q, narrow_tb_q;
	logic       clk_en_q;
	logic       div_q;
	logic [7:0] irq_stat_q, irq_mask_q, key_prev_q;
	logic [7:0] rdata_d;
	logic [7:0] wide_in_q, third_in_q;
	logic [1:0] narrow_in_q;
	logic [1:0] arm_q;
	pin_drive_t wide_drv_d, third_drv_d;
	logic [1:0] nar_out_d, nar_oe_d, nar_pu_d;

	// address decode, one hit per mapped register
	wire hit_wd = (i_req.addr == ADDR_WIDE_DATA);
	wire hit_wa = (i_req.addr == ADDR_WIDE_TYPE_A);
	wire hit_wb = (i_req.addr == ADDR_WIDE_TYPE_B);
	wire hit_td = (i_req.addr == ADDR_THIRD_DATA);
	wire hit_ta = (i_req.addr == ADDR_THIRD_TYPE_A);
	wire hit_tb = (i_req.addr == ADDR_THIRD_TYPE_B);
	wire hit_nd = (i_req.addr == ADDR_NARROW_DATA);
	wire hit_na = (i_req.addr == ADDR_NARROW_TYPE_A);
	wire hit_nb = (i_req.addr == ADDR_NARROW_TYPE_B);
	wire hit_ck = (i_req.addr == ADDR_CLK_CTRL);
	wire hit_is = (i_req.addr == ADDR_IRQ_STATUS);
	wire hit_im = (i_req.addr == ADDR_IRQ_MASK);

	// write strobes per register
	wire we_wd  = i_req.wr && hit_wd;
	wire we_wa  = i_req.wr && hit_wa;
	wire we_wb  = i_req.wr && hit_wb;
	wire we_td  = i_req.wr && hit_td;
	wire we_ta  = i_req.wr && hit_ta;
	wire we_tb  = i_req.wr && hit_tb;
	wire we_nd  = i_req.wr && hit_nd;
	wire we_na  = i_req.wr && hit_na;
	wire we_nb  = i_req.wr && hit_nb;
	wire we_ck  = i_req.wr && hit_ck;
	wire we_is  = i_req.wr && hit_is;
	wire we_im  = i_req.wr && hit_im;

	// clock source qualifications
	wire src_rc_wd   = (i_clk_source == SRC_RC) || (i_clk_source == SRC_WATCHDOG);
	wire crystal_sel = (i_clk_source == SRC_CRYSTAL);
	wire divided_clock_output_ok   = !crystal_sel && !i_timer_uses_crystal;
	wire divided_clock_output_on   = divided_clock_output_ok && clk_en_q;
	wire osc_pin_gpio = src_rc_wd && !i_timer_uses_crystal;

	// keypad edges: any change on a first-port pin, only once both samples are real;
	// the sampled pins start at zero after reset and would otherwise fake an edge
	wire [7:0] key_event = (wide_in_q ^ key_prev_q) & {8{arm_q[1]}};

	// first port data latch
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wide_data_q <= RST_DATA;
		end else if (we_wd) begin
			wide_data_q <= i_req.wdata;
		end
	end

	// first port output type a
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wide_ta_q <= RST_TYPE_A;
		end else if (we_wa) begin
			wide_ta_q <= i_req.wdata;
		end
	end

	// first port output type b
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wide_tb_q <= RST_TYPE_B;
		end else if (we_wb) begin
			wide_tb_q <= i_req.wdata;
		end
	end

	// third port data latch
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			third_data_q <= RST_DATA;
		end else if (we_td) begin
			third_data_q <= i_req.wdata;
		end
	end

	// third port output type a, bit five not implemented
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			third_ta_q <= RST_THIRD_TYPE_A;
		end else if (we_ta) begin
			third_ta_q <= i_req.wdata & THIRD_MODE_MASK;
		end
	end

	// third port output type b, bit five not implemented
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			third_tb_q <= RST_TYPE_B;
		end else if (we_tb) begin
			third_tb_q <= i_req.wdata & THIRD_MODE_MASK;
		end
	end

	// narrow port data latch, two bits only
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			narrow_data_q <= NARROW_MASK[1:0];
		end else if (we_nd) begin
			narrow_data_q <= i_req.wdata[1:0];
		end
	end

	// narrow port output type a
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			narrow_ta_q <= RST_NARROW_TYPE_A[1:0];
		end else if (we_na) begin
			narrow_ta_q <= i_req.wdata[1:0];
		end
	end

	// narrow port output type b
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			narrow_tb_q <= RST_TYPE_B[1:0];
		end else if (we_nb) begin
			narrow_tb_q <= i_req.wdata[1:0];
		end
	end

	// clock output enable; other bits of the control byte are reserved
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_en_q <= 1'b0;
		end else if (we_ck) begin
			clk_en_q <= i_req.wdata[CLK_OUT_EN_BIT];
		end
	end

	// keypad interrupt mask
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask_q <= RST_ZERO;
		end else if (we_im) begin
			irq_mask_q <= i_req.wdata;
		end
	end

	// keypad status: set wins over write-one-to-clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_q <= RST_ZERO;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(we_is ? i_req.wdata : RST_ZERO)) | key_event;
		end
	end

	// input sampling and clock divider
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wide_in_q   <= RST_ZERO;
			key_prev_q  <= RST_ZERO;
			third_in_q  <= RST_ZERO;
			narrow_in_q <= 2'b00;
			arm_q       <= 2'b00;
			div_q       <= 1'b0;
		end else begin
			wide_in_q   <= i_wide_pin;
			arm_q       <= {arm_q[0], 1'b1};
			key_prev_q  <= wide_in_q;
			third_in_q  <= i_third_pin;
			narrow_in_q <= i_narrow_pin;
			div_q       <= divided_clock_output_on ? ~div_q : 1'b0;
		end
	end

	// mode decode per pin from the type_a/type_b pair
	function automatic pin_mode_t decode_mode(input logic a, input logic b);
		pin_mode_t m;
		m = MODE_QUASI;
		case ({a, b})
			2'b00:   m = MODE_QUASI;
			2'b01:   m = MODE_PUSH_PULL;
			2'b10:   m = MODE_INPUT_ONLY;
			default: m = MODE_OPEN_DRAIN;
		endcase
		return m;
	endfunction

	// drive of one pin given value and mode; oe_n low while driven
	function automatic logic [2:0] drive(input logic v, input pin_mode_t m);
		logic [2:0] r;
		r = 3'b010;
		case (m)
			MODE_QUASI:      r = {v, ~v ? 1'b0 : 1'b1, 1'b1};
			MODE_PUSH_PULL:  r = {v, 1'b0, 1'b0};
			MODE_INPUT_ONLY: r = {1'b0, 1'b1, 1'b0};
			MODE_OPEN_DRAIN: r = {1'b0, v, 1'b0};
			default:         r = {1'b0, 1'b1, 1'b0};
		endcase
		return r;
	endfunction

	// first and third port pin drive, one slice per bit
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			logic wv;
			logic [2:0] wd, td;
			always_comb begin
				wv = wide_data_q[g];
				if (g == CMP_TWO_PIN_BIT && i_cmp_two_out_en) wv = i_comparator_two_output;
				if (g == CMP_ONE_PIN_BIT && i_cmp_one_out_en) wv = i_comparator_one_output;
				if (g == TIMER_PIN_BIT && i_timer_one_out_en) wv = i_timer_one_out;
				wd = drive(wv, decode_mode(wide_ta_q[g], wide_tb_q[g]));
				td = THIRD_INPUT_ONLY[g] ? 3'b010 :
				     drive(third_data_q[g], decode_mode(third_ta_q[g], third_tb_q[g]));
				wide_drv_d.out[g]      = wd[2];
				wide_drv_d.oe_n[g]     = wd[1];
				wide_drv_d.pull_en[g]  = wd[0];
				third_drv_d.out[g]     = td[2];
				third_drv_d.oe_n[g]    = td[1];
				third_drv_d.pull_en[g] = td[0];
			end
		end
	endgenerate

	// narrow port: alternate functions override ordinary pin use
	always_comb begin
		logic [2:0] d0, d1;
		d0 = drive(narrow_data_q[NARROW_CLK_BIT],
		           decode_mode(narrow_ta_q[NARROW_CLK_BIT], narrow_tb_q[NARROW_CLK_BIT]));
		d1 = drive(narrow_data_q[NARROW_OSC_BIT],
		           decode_mode(narrow_ta_q[NARROW_OSC_BIT], narrow_tb_q[NARROW_OSC_BIT]));
		if (crystal_sel) d0 = 3'b011;                    // amplifier owns the pin, latch off
		else if (divided_clock_output_on) d0 = {div_q, 2'b00};
		if (!osc_pin_gpio) d1 = 3'b010;                  // oscillator input, not driven
		nar_out_d = {d1[2], d0[2]};
		nar_oe_d  = {d1[1], d0[1]};
		nar_pu_d  = {d1[0], d0[0]};
	end

	// read mux: pin registers read the pins; unimplemented bits zero
	assign rdata_d =
		hit_wd ? wide_in_q :
		hit_wa ? wide_ta_q :
		hit_wb ? wide_tb_q :
		hit_td ? third_in_q :
		hit_ta ? third_ta_q :
		hit_tb ? third_tb_q :
		hit_nd ? {6'h00, narrow_in_q} :
		hit_na ? {6'h00, narrow_ta_q} :
		hit_nb ? {6'h00, narrow_tb_q} :
		hit_ck ? {1'b0, clk_en_q, 6'h00} :
		hit_is ? irq_stat_q :
		hit_im ? irq_mask_q : RST_ZERO;                             // none fixed at one

	// registered bus, timer and keypad outputs
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata          <= RST_ZERO;
			o_timer_one_pin  <= 1'b0;
			o_keypad_input   <= RST_ZERO;
			o_irq            <= 1'b0;
		end else begin
			o_rdata          <= i_req.rd ? rdata_d : RST_ZERO;
			o_timer_one_pin  <= wide_in_q[TIMER_PIN_BIT];
			o_keypad_input   <= wide_in_q;
			o_irq            <= |(irq_stat_q & irq_mask_q);
		end
	end

	// registered pin drives; reset holds every pin input-only, no pull-up
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wide_drive     <= '{out: RST_ZERO, oe_n: RST_DATA, pull_en: RST_ZERO};
			o_third_drive    <= '{out: RST_ZERO, oe_n: RST_DATA, pull_en: RST_ZERO};
			o_narrow_out     <= 2'b00;
			o_narrow_oe_n    <= NARROW_MASK[1:0];
			o_narrow_pull_en <= 2'b00;
		end else begin
			o_wide_drive     <= wide_drv_d;
			o_third_drive    <= third_drv_d;
			o_narrow_out     <= nar_out_d;
			o_narrow_oe_n    <= nar_oe_d;
			o_narrow_pull_en <= nar_pu_d;
		end
	end

endmodule // micro_port

//--- tb/port_board.sv
// board circuitry model that resolves every port pin
`timescale 1ns/1ps
module port_board
	import port_pkg::*;
(
	input  wire pin_drive_t i_wide_drive,
	input  wire pin_drive_t i_third_drive,
	input  wire logic [1:0] i_narrow_out,
	input  wire logic [1:0] i_narrow_oe_n,
	input  wire logic [7:0] i_wide_ext,
	input  wire logic [7:0] i_third_ext,
	input  wire logic [1:0] i_narrow_ext,
	output logic [7:0]      o_wide_pin,
	output logic [7:0]      o_third_pin,
	output logic [1:0]      o_narrow_pin
);
	// a pin follows the block where it drives, else the board source
	assign o_wide_pin = i_wide_drive.oe_n & i_wide_ext | ~i_wide_drive.oe_n & i_wide_drive.out;
	assign o_third_pin = i_third_drive.oe_n & i_third_ext | ~i_third_drive.oe_n & i_third_drive.out;
	assign o_narrow_pin = i_narrow_oe_n & i_narrow_ext | ~i_narrow_oe_n & i_narrow_out;
endmodule // port_board

//--- tb/micro_port_monitor.sv
// checker of port relations of the port block
`timescale 1ns/1ps
module port_monitor
	import port_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_arst_n,
	input wire reg_req_t   i_req,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] i_wide_pin,
	input wire pin_drive_t o_wide_drive,
	input wire pin_drive_t o_third_drive,
	input wire logic [1:0] o_narrow_out,
	input wire logic [1:0] o_narrow_oe_n,
	input wire logic [1:0] i_clk_source,
	input wire logic       i_timer_uses_crystal,
	input wire logic       o_timer_one_pin,
	input wire logic [7:0] o_keypad_input,
	input wire logic       o_irq
);
	logic [1:0] up_q;
	logic       ok;
	// history is trusted three edges after reset
	assign ok = up_q == 2'h3;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			up_q <= 2'h0;
		else if (!ok)
			up_q <= up_q + 2'h1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	a_rdata_idle: assert property (ok && !$past(i_req.rd) |-> o_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_third_bit_five: assert property (o_third_drive.oe_n[5] && !o_third_drive.pull_en[5])
		else $error("third port bit five driven");
	a_quasi_pull: assert property (
		(o_wide_drive.pull_en & (o_wide_drive.oe_n ^ o_wide_drive.out)) == 8'h00)
		else $error("pull-up on a pin not in quasi mode");
	a_crystal_owns_pin: assert property (
		ok && $past(i_clk_source) == SRC_CRYSTAL |-> o_narrow_oe_n[0] && !o_narrow_out[0])
		else $error("narrow bit zero driven under crystal");
	a_osc_pin_free: assert property (
		ok && ($past(i_clk_source[1]) || $past(i_timer_uses_crystal)) |-> o_narrow_oe_n[1])
		else $error("narrow bit one driven while owned by oscillator");
	a_keypad_follow: assert property (
		ok && $past(i_wide_pin, 2) == $past(i_wide_pin) |-> o_keypad_input == $past(i_wide_pin))
		else $error("keypad inputs do not follow pins");
	a_timer_follow: assert property (
		ok && $past(i_wide_pin[7], 2) == $past(i_wide_pin[7]) |-> o_timer_one_pin == $past(i_wide_pin[7]))
		else $error("timer pin does not follow bit seven");
	a_mask_quiet: assert property (
		i_req.wr && i_req.addr == ADDR_IRQ_MASK && i_req.wdata == 8'h00 |-> ##2 !o_irq)
		else $error("interrupt high with all sources masked");
endmodule // port_monitor

bind micro_port port_monitor u_mon (.i_clk, .i_arst_n, .i_req, .o_rdata, .i_wide_pin,
	.o_wide_drive, .o_third_drive, .o_narrow_out, .o_narrow_oe_n, .i_clk_source,
	.i_timer_uses_crystal, .o_timer_one_pin, .o_keypad_input, .o_irq);

//--- tb/micro_port_tb_top.sv
// self-checking bench of the port block with board model
`timescale 1ns/1ps
module micro_port_tb_top;
	import port_pkg::*;
	logic       i_clk, i_arst_n, tcry, tmr_o, tmr_en, tmr_pin, cmp, irq, c0;
	logic       rd_q = 1'b0;
	reg_req_t   i_req;
	pin_drive_t wide_drv, third_drv;
	logic [7:0] o_rdata, wide_ext, third_ext, wide_pin, third_pin, keypad, v;
	logic [1:0] n_out, n_oe_n, n_pull, narrow_ext, narrow_pin, src;
	logic [7:0] exp_q[$];
	int         fail_count, comparisons;

	micro_port DUT (.i_clk, .i_arst_n, .i_req, .o_rdata, .i_wide_pin(wide_pin),
		.o_wide_drive(wide_drv), .i_third_pin(third_pin), .o_third_drive(third_drv),
		.i_narrow_pin(narrow_pin), .o_narrow_out(n_out), .o_narrow_oe_n(n_oe_n),
		.o_narrow_pull_en(n_pull), .i_clk_source(src), .i_timer_uses_crystal(tcry),
		.i_comparator_one_output(cmp), .i_comparator_two_output(cmp),
		.i_cmp_one_out_en(cmp), .i_cmp_two_out_en(cmp), .i_timer_one_out(tmr_o),
		.i_timer_one_out_en(tmr_en), .o_timer_one_pin(tmr_pin),
		.o_keypad_input(keypad), .o_irq(irq));
	port_board board (.i_wide_drive(wide_drv), .i_third_drive(third_drv),
		.i_narrow_out(n_out), .i_narrow_oe_n(n_oe_n), .i_wide_ext(wide_ext),
		.i_third_ext(third_ext), .i_narrow_ext(narrow_ext), .o_wide_pin(wide_pin),
		.o_third_pin(third_pin), .o_narrow_pin(narrow_pin));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic wrap_up;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		comparisons++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, want);
		end
	endtask
	// bus tasks leave the request up; tick lowers it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_req <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk);
	endtask
	task automatic tick(input int n);
		i_req <= '0;
		repeat (n) @(posedge i_clk);
	endtask
	// read data stand in the cycle after the strobe
	always @(posedge i_clk) begin
		if (rd_q)
			chk(o_rdata, exp_q.pop_front());
		rd_q <= i_req.rd;
	end
	initial begin
		#2000000;
		fail_count++;
		$display("ERROR %0t: run timed out", $time);
		wrap_up;
	end
	initial begin
		i_arst_n = 1'b0;
		i_req = '0;
		{tcry, tmr_o, tmr_en, cmp} = '0;
		wide_ext = 8'hA5;
		third_ext = 8'h3C;
		narrow_ext = 2'h2;
		src = SRC_RC;
		v = $urandom(87);
		repeat (4) @(posedge i_clk);
		chk(wide_drv.oe_n & third_drv.oe_n, 8'hFF);
		chk(wide_drv.pull_en | third_drv.pull_en, 8'h00);
		chk({6'h00, n_oe_n}, 8'h03);
		i_arst_n <= 1'b1;
		tick(1);
		rd(ADDR_WIDE_TYPE_A, RST_TYPE_A);
		rd(ADDR_WIDE_TYPE_B, RST_TYPE_B);
		rd(ADDR_THIRD_TYPE_A, RST_THIRD_TYPE_A);
		rd(ADDR_NARROW_TYPE_A, RST_NARROW_TYPE_A);
		rd(ADDR_NARROW_TYPE_B, RST_TYPE_B);
		rd(ADDR_CLK_CTRL, 8'h00);
		rd(ADDR_WIDE_DATA, wide_ext);
		rd(ADDR_THIRD_DATA, third_ext);
		rd(ADDR_NARROW_DATA, {6'h00, narrow_ext});
		repeat (3) begin
			v = $urandom;
			wr(ADDR_WIDE_TYPE_B, v);
			wr(ADDR_THIRD_TYPE_B, v & THIRD_MODE_MASK);
			rd(ADDR_WIDE_TYPE_B, v);
			rd(ADDR_THIRD_TYPE_B, v & THIRD_MODE_MASK);
			rd(ADDR_WIDE_TYPE_A, RST_TYPE_A);
		end
		// keypad event on pins 0 and 7, only pin 0 unmasked
		wr(ADDR_IRQ_MASK, 8'h01);
		wide_ext <= wide_ext ^ 8'h81;
		tick(4);
		chk({7'h00, irq}, 8'h01);
		chk({7'h00, tmr_pin}, {7'h00, wide_ext[7]});
		rd(ADDR_IRQ_STATUS, 8'h81);
		wr(ADDR_IRQ_STATUS, 8'h81);
		wr(ADDR_IRQ_MASK, 8'h00);
		tick(3);
		chk({7'h00, irq}, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h00);
		// every output type code on the wide port; comparator bits start low
		v = ($urandom | 8'h80) & 8'hBE;
		wr(ADDR_WIDE_DATA, v);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_WIDE_TYPE_A, m[1] ? 8'hFF : 8'h00);
			wr(ADDR_WIDE_TYPE_B, m[0] ? 8'hFF : 8'h00);
			tick(2);
			chk(wide_drv.oe_n, m == 1 ? 8'h00 : m == 2 ? 8'hFF : v);
		end
		tmr_en <= 1'b1;
		cmp <= 1'b1;
		tick(2);
		chk({5'h00, wide_drv.oe_n[7], wide_drv.oe_n[6], wide_drv.oe_n[0]}, 8'h03);
		// narrow port pushes zero, then clock output and its owners
		wr(ADDR_NARROW_TYPE_A, 8'h00);
		wr(ADDR_NARROW_TYPE_B, 8'h03);
		wr(ADDR_NARROW_DATA, 8'h00);
		wr(ADDR_CLK_CTRL, 8'h40);
		rd(ADDR_NARROW_TYPE_B, 8'h03);
		tick(3);
		c0 = n_out[0];
		tick(1);
		chk({6'h00, n_oe_n[0], n_out[0]}, {7'h00, ~c0});
		chk({7'h00, n_oe_n[1]}, 8'h00);
		tcry <= 1'b1;
		tick(3);
		chk({5'h00, n_oe_n, n_out[0]}, 8'h04);
		src <= SRC_CRYSTAL;
		tcry <= 1'b0;
		tick(3);
		chk({5'h00, n_oe_n, n_out[0]}, 8'h06);
		wrap_up;
	end
endmodule // micro_port_tb_top
